// file: src/oamd_cfg.svh
`ifndef OAMD_CFG_SVH
`define OAMD_CFG_SVH

// Instruction word layout (24-bit program word)
`define OAMD_IW_W        24
`define OAMD_DW          16
// Class field: top four bits of the word
`define OAMD_CLS_HI      23
`define OAMD_CLS_LO      20
`define OAMD_CLS_NOP     4'h0
`define OAMD_CLS_MOVE    4'h1
`define OAMD_CLS_MAC     4'h2
`define OAMD_CLS_BRANCH  4'h3
`define OAMD_CLS_INTERRUPT_DISABLE_COUNT_OP    4'h4
`define OAMD_CLS_UNLINK  4'h5
`define OAMD_CLS_LIT8    4'h6
`define OAMD_CLS_LIT16   4'h7
// Move encoding fields
`define OAMD_SRC_MODE_HI 19
`define OAMD_SRC_MODE_LO 17
`define OAMD_DST_MODE_HI 16
`define OAMD_DST_MODE_LO 14
`define OAMD_OFS_HI      13
`define OAMD_OFS_LO      10
`define OAMD_DREG_HI     9
`define OAMD_DREG_LO     6
`define OAMD_SREG_HI     3
`define OAMD_SREG_LO     0
`define OAMD_LOFS_HI     5
`define OAMD_LOFS_LO     4
// MAC encoding fields
`define OAMD_MACOP_HI    19
`define OAMD_MACOP_LO    17
`define OAMD_XP_BIT      7
`define OAMD_XM_HI       6
`define OAMD_XM_LO       4
`define OAMD_YP_BIT      3
`define OAMD_YM_HI       2
`define OAMD_YM_LO       0
`define OAMD_MOFS_HI     16
`define OAMD_MOFS_LO     13
// Literal fields
`define OAMD_LIT8_HI     7
`define OAMD_LIT14_HI    13
`define OAMD_LIT16_HI    15
// Register numbers
`define OAMD_NREG        16
`define OAMD_XPA         4'h8
`define OAMD_XPB         4'h9
`define OAMD_YPA         4'ha
`define OAMD_YPB         4'hb
`define OAMD_FRAME_REG   4'he
`define OAMD_STACK_REG   4'hf
// Word step for pre/post modification
`define OAMD_STEP        16'h0002

`endif

// file: src/oamd_pkg.sv
package oamd_pkg;

	// Move-class addressing modes
	typedef enum logic [2:0] {
		OAMD_AM_DIRECT = 3'h0,
		OAMD_AM_IND    = 3'h1,
		OAMD_AM_POSTI  = 3'h2,
		OAMD_AM_PREI   = 3'h3,
		OAMD_AM_INDEX  = 3'h4,
		OAMD_AM_LITOFS = 3'h5,
		OAMD_AM_LIT8   = 3'h6,
		OAMD_AM_LIT16  = 3'h7
	} oamd_am_e;

	// MAC prefetch modes
	typedef enum logic [2:0] {
		OAMD_PM_IND   = 3'h0,
		OAMD_PM_POST2 = 3'h1,
		OAMD_PM_POST4 = 3'h2,
		OAMD_PM_POST6 = 3'h3,
		OAMD_PM_INDEX = 3'h4,
		OAMD_PM_NONE  = 3'h7
	} oamd_pm_e;

	// Dual-source operation group
	typedef enum logic [2:0] {
		OAMD_MAC_CLR  = 3'h0,
		OAMD_MAC_ED   = 3'h1,
		OAMD_MAC_SQUARED_DISTANCE_ACCUM_OP = 3'h2,
		OAMD_MAC_MAC  = 3'h3,
		OAMD_MAC_MPY  = 3'h4,
		OAMD_MAC_MPYN = 3'h5,
		OAMD_MAC_STP  = 3'h6,
		OAMD_MAC_MSUB = 3'h7
	} oamd_macop_e;

	// Decoder state, one-hot
	typedef enum logic [1:0] {
		OAMD_ST_IDLE = 2'b01,
		OAMD_ST_WAIT = 2'b10
	} oamd_st_e;

	// One effective-address channel
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} oamd_ea_s;

	// Decoded operand bundle
	typedef struct packed {
		logic        has_operand;
		logic        implied;
		logic        lit_valid;
		logic [15:0] lit;
		logic        branch;
		logic [15:0] branch_target;
		logic        interrupt_disable_count_op;
		logic [13:0] interrupt_disable_count_op_count;
		logic        illegal;
	} oamd_dec_s;

endpackage

// file: src/oamd_regfile.sv
`timescale 1ns/1ps
`include "oamd_cfg.svh"

// Working-register file: two combinational read ports for address forming,
// registered read port for data out, two write ports (pointer updates).
module oamd_regfile #(
	parameter int NREG = `OAMD_NREG,
	parameter int DW   = `OAMD_DW
) (
	input  wire logic          clock_in,
	input  wire logic          sys_rst_in,
	input  wire logic [3:0]    ra_in,
	output logic      [DW-1:0] ra_out,
	input  wire logic [3:0]    rb_in,
	output logic      [DW-1:0] rb_out,
	input  wire logic [3:0]    rq_in,
	output logic      [DW-1:0] rq_out,
	input  wire logic          wa_en_in,
	input  wire logic [3:0]    wa_in,
	input  wire logic [DW-1:0] wa_data_in,
	input  wire logic          wb_en_in,
	input  wire logic [3:0]    wb_in,
	input  wire logic [DW-1:0] wb_data_in
);

	logic [DW-1:0] mem_r [NREG];  // Register storage

	// Port b wins when both ports hit one register; MAC uses distinct ones
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			always_ff @(posedge clock_in) begin
				if (sys_rst_in) begin
					mem_r[g] <= '0;
				end else if (wb_en_in && wb_in == 4'(g)) begin
					mem_r[g] <= wb_data_in;
				end else if (wa_en_in && wa_in == 4'(g)) begin
					mem_r[g] <= wa_data_in;
				end
			end
		end
	endgenerate

	assign ra_out = mem_r[ra_in];
	assign rb_out = mem_r[rb_in];

	// Registered inspection port
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			rq_out <= '0;
		end else begin
			rq_out <= mem_r[rq_in];
		end
	end

endmodule // oamd_regfile

// file: src/oamd_decode.sv
`timescale 1ns/1ps
`include "oamd_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Moves also accept register-indexed indirect mode
// - Source, destination modes independent; shared offset field
// - Move modes: direct, indirect, pre/post, indexed, literals
// - Only pointers eight to eleven for MAC
// - Pointers 8,9 to X; 10,11 to Y
// - MAC indexing only pointer nine and eleven
// - MAC: indirect, post-modify 2/4/6, indexed
// - Reduced modes cover whole dual-source group
// - Branch target from 16-bit signed literal
// - Interrupt-disable count from 14-bit literal
// - Frame unlink operands implied by opcode
// - No-operation decodes with no address
module oamd_decode #(
	parameter int DW = `OAMD_DW
) (
	input  wire logic                    clock_in,
	input  wire logic                    sys_rst_in,
	input  wire logic                    instr_valid_in,
	input  wire logic [`OAMD_IW_W-1:0]   instr_in,
	input  wire logic [15:0]             pc_in,
	input  wire logic [3:0]              reg_sel_in,
	output logic                         instr_ready_out,
	output oamd_pkg::oamd_ea_s           src_ea_out,
	output oamd_pkg::oamd_ea_s           dst_ea_out,
	output oamd_pkg::oamd_ea_s           x_ea_out,
	output oamd_pkg::oamd_ea_s           y_ea_out,
	output oamd_pkg::oamd_dec_s          dec_out,
	output logic [DW-1:0]                reg_data_out
);

	////////////////////////////////////////////////////////////////////
	// Field extraction
	logic [3:0]              cls;           // Instruction class
	oamd_pkg::oamd_am_e      src_mode;      // Move source mode
	oamd_pkg::oamd_am_e      dst_mode;      // Move destination mode
	logic [3:0]              ofs_reg;       // Shared offset register field
	logic [3:0]              sreg;          // Source register
	logic [3:0]              dreg;          // Destination register
	oamd_pkg::oamd_pm_e      xmode;         // X prefetch mode
	oamd_pkg::oamd_pm_e      ymode;         // Y prefetch mode
	logic [3:0]              xreg;          // X pointer number
	logic [3:0]              yreg;          // Y pointer number
	logic [3:0]              mofs_reg;      // MAC offset register
	logic [DW-1:0]           s_val;         // Port a read
	logic [DW-1:0]           d_val;         // Port b read
	logic [DW-1:0]           o_val;         // Offset read value
	logic [DW-1:0]           x_val;
	logic [DW-1:0]           y_val;
	logic [DW-1:0]           s_lofs;        // Literal offset, scaled
	logic [DW-1:0]           d_lofs;
	logic [3:0]              ra;
	logic [3:0]              rb;
	logic                    wa_en;
	logic                    wb_en;
	logic [DW-1:0]           wa_data;
	logic [DW-1:0]           wb_data;
	logic                    is_move;
	logic                    is_mac;
	logic                    take;
	oamd_pkg::oamd_st_e      state_r;
	oamd_pkg::oamd_st_e      state_nxt;

	assign cls      = instr_in[`OAMD_CLS_HI:`OAMD_CLS_LO];
	assign src_mode = oamd_pkg::oamd_am_e'(instr_in[`OAMD_SRC_MODE_HI:`OAMD_SRC_MODE_LO]);
	assign dst_mode = oamd_pkg::oamd_am_e'(instr_in[`OAMD_DST_MODE_HI:`OAMD_DST_MODE_LO]);
	assign ofs_reg  = instr_in[`OAMD_OFS_HI:`OAMD_OFS_LO];
	assign sreg     = instr_in[`OAMD_SREG_HI:`OAMD_SREG_LO];
	assign dreg     = instr_in[`OAMD_DREG_HI:`OAMD_DREG_LO];
	assign mofs_reg = instr_in[`OAMD_MOFS_HI:`OAMD_MOFS_LO];
	assign xmode    = oamd_pkg::oamd_pm_e'(instr_in[`OAMD_XM_HI:`OAMD_XM_LO]);
	assign ymode    = oamd_pkg::oamd_pm_e'(instr_in[`OAMD_YM_HI:`OAMD_YM_LO]);
	// Pointer select bit picks a or b of each space; others never decode
	assign xreg     = instr_in[`OAMD_XP_BIT] ? `OAMD_XPB : `OAMD_XPA;
	assign yreg     = instr_in[`OAMD_YP_BIT] ? `OAMD_YPB : `OAMD_YPA;
	// Literal offset: two bits, in words
	assign s_lofs   = {13'h0000, instr_in[`OAMD_LOFS_HI:`OAMD_LOFS_LO], 1'b0};
	assign d_lofs   = s_lofs;

	assign is_move  = (cls == `OAMD_CLS_MOVE);
	assign is_mac   = (cls == `OAMD_CLS_MAC);
	assign take     = instr_valid_in && instr_ready_out;

	////////////////////////////////////////////////////////////////////
	// Read port steering: MAC reads X/Y pointers, moves read operands
	assign ra = is_mac ? xreg : sreg;
	assign rb = is_mac ? yreg : dreg;

	// Offset register shared port through the inspection side is too late,
	// so offset values come through a third combinational selection
	logic [DW-1:0] ofs_val_a;
	logic [DW-1:0] ofs_val_b;

	oamd_regfile #(
		.DW (DW)
	) u_regs (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.ra_in      (ra),
		.ra_out     (ofs_val_a),
		.rb_in      (rb),
		.rb_out     (ofs_val_b),
		.rq_in      (reg_sel_in),
		.rq_out     (reg_data_out),
		.wa_en_in   (wa_en),
		.wa_in      (ra),
		.wa_data_in (wa_data),
		.wb_en_in   (wb_en),
		.wb_in      (rb),
		.wb_data_in (wb_data)
	);

	assign s_val = ofs_val_a;
	assign d_val = ofs_val_b;
	assign x_val = ofs_val_a;
	assign y_val = ofs_val_b;

	// Offset register value is mirrored by a shadow copy written at the same edge as the register file
	logic [DW-1:0] ofs_shadow_r [16];  // Mirror for the offset port
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < 16; i++) ofs_shadow_r[i] <= '0;
		end else begin
			if (wa_en) ofs_shadow_r[ra] <= wa_data;
			if (wb_en) ofs_shadow_r[rb] <= wb_data;
		end
	end
	assign o_val = is_mac ? ofs_shadow_r[mofs_reg] : ofs_shadow_r[ofs_reg];

	////////////////////////////////////////////////////////////////////
	// Move-class address forming for one operand
	function automatic oamd_pkg::oamd_ea_s move_ea(input oamd_pkg::oamd_am_e m,
		input logic [DW-1:0] r, input logic [DW-1:0] ofs, input logic [DW-1:0] lofs);
		oamd_pkg::oamd_ea_s e;
		e.valid = 1'b1;
		e.addr  = r;
		unique case (m)
			oamd_pkg::OAMD_AM_DIRECT: e.valid = 1'b0;
			oamd_pkg::OAMD_AM_IND:    e.addr  = r;
			oamd_pkg::OAMD_AM_POSTI:  e.addr  = r;
			oamd_pkg::OAMD_AM_PREI:   e.addr  = r + `OAMD_STEP;
			oamd_pkg::OAMD_AM_INDEX:  e.addr  = r + ofs;
			oamd_pkg::OAMD_AM_LITOFS: e.addr  = r + lofs;
			oamd_pkg::OAMD_AM_LIT8,
			oamd_pkg::OAMD_AM_LIT16:  e.valid = 1'b0;
		endcase
		return e;
	endfunction

	// Writeback enable for a move operand; only pre/post modify
	function automatic logic modifies(input oamd_pkg::oamd_am_e m);
		return (m == oamd_pkg::OAMD_AM_POSTI) || (m == oamd_pkg::OAMD_AM_PREI);
	endfunction

	// MAC prefetch address; indexing only on the b pointer of each space
	function automatic oamd_pkg::oamd_ea_s mac_ea(input oamd_pkg::oamd_pm_e m,
		input logic is_b, input logic [DW-1:0] r, input logic [DW-1:0] ofs);
		oamd_pkg::oamd_ea_s e;
		e.valid = 1'b1;
		e.addr  = r;
		if (m == oamd_pkg::OAMD_PM_INDEX) begin
			e.valid = is_b;
			e.addr  = r + ofs;
		end else if (m == oamd_pkg::OAMD_PM_NONE) begin
			e.valid = 1'b0;
		end else if (m != oamd_pkg::OAMD_PM_IND && m != oamd_pkg::OAMD_PM_POST2 &&
			m != oamd_pkg::OAMD_PM_POST4 && m != oamd_pkg::OAMD_PM_POST6) begin
			e.valid = 1'b0;
		end
		return e;
	endfunction

	function automatic logic [DW-1:0] mac_step(input oamd_pkg::oamd_pm_e m);
		unique case (m)
			oamd_pkg::OAMD_PM_POST2: mac_step = 16'h0002;
			oamd_pkg::OAMD_PM_POST4: mac_step = 16'h0004;
			oamd_pkg::OAMD_PM_POST6: mac_step = 16'h0006;
			default:                 mac_step = 16'h0000;
		endcase
	endfunction

	oamd_pkg::oamd_ea_s src_ea;
	oamd_pkg::oamd_ea_s dst_ea;
	oamd_pkg::oamd_ea_s x_ea;
	oamd_pkg::oamd_ea_s y_ea;
	assign src_ea = move_ea(src_mode, s_val, o_val, s_lofs);
	assign dst_ea = move_ea(dst_mode, d_val, o_val, d_lofs);
	assign x_ea   = mac_ea(xmode, instr_in[`OAMD_XP_BIT], x_val, o_val);
	assign y_ea   = mac_ea(ymode, instr_in[`OAMD_YP_BIT], y_val, o_val);

	////////////////////////////////////////////////////////////////////
	// Pointer writeback happens at the accepting edge, after the address
	// above was formed from the old value
	always_comb begin
		wa_en   = 1'b0;
		wb_en   = 1'b0;
		wa_data = s_val;
		wb_data = d_val;
		if (take && is_move) begin
			wa_en   = modifies(src_mode);
			wa_data = s_val + `OAMD_STEP;
			wb_en   = modifies(dst_mode);
			wb_data = d_val + `OAMD_STEP;
		end else if (take && is_mac) begin
			wa_en   = x_ea.valid && (mac_step(xmode) != 16'h0000);
			wa_data = x_val + mac_step(xmode);
			wb_en   = y_ea.valid && (mac_step(ymode) != 16'h0000);
			wb_data = y_val + mac_step(ymode);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Handshake: one instruction per two cycles so writebacks settle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			oamd_pkg::OAMD_ST_IDLE: if (instr_valid_in) state_nxt = oamd_pkg::OAMD_ST_WAIT;
			oamd_pkg::OAMD_ST_WAIT: state_nxt = oamd_pkg::OAMD_ST_IDLE;
			default:                state_nxt = oamd_pkg::OAMD_ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_r <= oamd_pkg::OAMD_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign instr_ready_out = (state_r == oamd_pkg::OAMD_ST_IDLE);

	////////////////////////////////////////////////////////////////////
	// Registered results, held until the next accepted instruction
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			src_ea_out <= '0;
			dst_ea_out <= '0;
			x_ea_out   <= '0;
			y_ea_out   <= '0;
			dec_out    <= '0;
		end else if (take) begin
			src_ea_out <= is_move ? src_ea : '0;
			dst_ea_out <= is_move ? dst_ea : '0;
			x_ea_out   <= is_mac ? x_ea : '0;
			y_ea_out   <= is_mac ? y_ea : '0;
			dec_out    <= '0;
			unique case (cls)
				`OAMD_CLS_NOP: dec_out.has_operand <= 1'b0;
				`OAMD_CLS_MOVE, `OAMD_CLS_MAC: dec_out.has_operand <= 1'b1;
				`OAMD_CLS_BRANCH: begin
					dec_out.has_operand   <= 1'b1;
					dec_out.branch        <= 1'b1;
					dec_out.branch_target <= pc_in + instr_in[`OAMD_LIT16_HI:0];
				end
				`OAMD_CLS_INTERRUPT_DISABLE_COUNT_OP: begin
					dec_out.has_operand <= 1'b1;
					dec_out.interrupt_disable_count_op        <= 1'b1;
					dec_out.interrupt_disable_count_op_count  <= instr_in[`OAMD_LIT14_HI:0];
				end
				`OAMD_CLS_UNLINK: begin
					dec_out.has_operand <= 1'b1;
					dec_out.implied     <= 1'b1;
				end
				`OAMD_CLS_LIT8: begin
					dec_out.has_operand <= 1'b1;
					dec_out.lit_valid   <= 1'b1;
					dec_out.lit         <= {8'h00, instr_in[`OAMD_LIT8_HI:0]};
				end
				`OAMD_CLS_LIT16: begin
					dec_out.has_operand <= 1'b1;
					dec_out.lit_valid   <= 1'b1;
					dec_out.lit         <= instr_in[`OAMD_LIT16_HI:0];
				end
				default: dec_out.illegal <= 1'b1;
			endcase
		end
	end

endmodule // oamd_decode

// file: verification/oamd_decode_assertions.sv
`timescale 1ns/1ps
`include "oamd_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Port-level checks of the operand decoder
module oamd_decode_assertions #(
	parameter int DW = `OAMD_DW
) (
	input wire logic                  clock_in,
	input wire logic                  sys_rst_in,
	input wire logic                  instr_valid_in,
	input wire logic [`OAMD_IW_W-1:0] instr_in,
	input wire logic [15:0]           pc_in,
	input wire logic [3:0]            reg_sel_in,
	input wire logic                  instr_ready_out,
	input wire oamd_pkg::oamd_ea_s    src_ea_out,
	input wire oamd_pkg::oamd_ea_s    dst_ea_out,
	input wire oamd_pkg::oamd_ea_s    x_ea_out,
	input wire oamd_pkg::oamd_ea_s    y_ea_out,
	input wire oamd_pkg::oamd_dec_s   dec_out,
	input wire logic [DW-1:0]         reg_data_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	logic       take;	// Instruction accepted at this edge
	logic [3:0] cls;	// Class field of the offered word
	assign take = instr_valid_in && instr_ready_out;
	assign cls  = instr_in[`OAMD_CLS_HI:`OAMD_CLS_LO];

	////////////////////////////////////////////////////////////////////////
	// One idle cycle after each take keeps the pointer write-back ahead of the next read
	AST_READY_GAP: assert property (take |=> !instr_ready_out ##1 instr_ready_out)
		else $error("ready did not drop for exactly one cycle after a take");
	AST_NOP_NO_EA: assert property (take && cls == `OAMD_CLS_NOP |=>
		!src_ea_out.valid && !dst_ea_out.valid && !x_ea_out.valid && !y_ea_out.valid && !dec_out.has_operand)
		else $error("no-operation produced an operand or address");
	AST_BRANCH: assert property (take && cls == `OAMD_CLS_BRANCH |=>
		dec_out.branch && dec_out.branch_target == $past(pc_in) + $past(instr_in[15:0]))
		else $error("branch target differs from the literal field");
	AST_INTERRUPT_DISABLE_COUNT_OP: assert property (take && cls == `OAMD_CLS_INTERRUPT_DISABLE_COUNT_OP |=>
		dec_out.interrupt_disable_count_op && dec_out.interrupt_disable_count_op_count == $past(instr_in[13:0]))
		else $error("interrupt-disable count differs from the literal field");
	AST_UNLINK: assert property (take && cls == `OAMD_CLS_UNLINK |=> dec_out.implied)
		else $error("frame unlink not marked as implied");
	AST_X_INDEX: assert property (take && cls == `OAMD_CLS_MAC &&
		!instr_in[7] && instr_in[6:4] == 3'h4 |=> !x_ea_out.valid)
		else $error("indexed prefetch accepted on the first X pointer");
	AST_Y_INDEX: assert property (take && cls == `OAMD_CLS_MAC &&
		!instr_in[3] && instr_in[2:0] == 3'h4 |=> !y_ea_out.valid)
		else $error("indexed prefetch accepted on the first Y pointer");
	AST_MAC_VALID: assert property (take && cls == `OAMD_CLS_MAC &&
		instr_in[6:4] < 3'h4 && instr_in[2:0] < 3'h4 |=> x_ea_out.valid && y_ea_out.valid)
		else $error("dual-source prefetch produced no address");
	AST_HOLD: assert property (!take |=> $stable(dec_out) && $stable(x_ea_out))
		else $error("decoded outputs moved without a new instruction");

	// Main scenarios reached
	COV_MAC: cover property (take && cls == `OAMD_CLS_MAC);
	COV_MOVE: cover property (take && cls == `OAMD_CLS_MOVE);
	COV_BRANCH: cover property (take && cls == `OAMD_CLS_BRANCH);
endmodule // oamd_decode_assertions

bind oamd_decode oamd_decode_assertions #(.DW(DW)) u_oamd_decode_assertions (
	.clock_in(clock_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
	.pc_in(pc_in), .reg_sel_in(reg_sel_in), .instr_ready_out(instr_ready_out), .src_ea_out(src_ea_out),
	.dst_ea_out(dst_ea_out), .x_ea_out(x_ea_out), .y_ea_out(y_ea_out), .dec_out(dec_out),
	.reg_data_out(reg_data_out)
);

// file: verification/oamd_stream_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Instruction stream: offers one word, holds it until ready is seen at an edge
module oamd_stream_model (
	input  wire logic        clock_in,
	input  wire logic        instr_ready_in,
	output logic             instr_valid_out,
	output logic [23:0]      instr_out
);
	initial begin
		instr_valid_out = 1'b0;
		instr_out       = 24'h000000;
	end

	// Called just after an edge; the words handed in keep prefetch pointers in their space
	task automatic send(input logic [23:0] w, output logic ok);
		int n;
		n = 0;
		// Let one edge pass so valid never falls and rises in one time step
		@(posedge clock_in);
		#1;
		instr_valid_out = 1'b1;
		instr_out       = w;
		// Ready is judged where settled, then the edge that samples it is taken
		while (instr_ready_in !== 1'b1 && n < 20) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		ok = (instr_ready_in === 1'b1);
		@(posedge clock_in);
		#1;
		// Released word shows its inverse, never a stale copy
		instr_valid_out = 1'b0;
		instr_out       = ~w;
	endtask
endmodule // oamd_stream_model

// file: verification/testbench.sv
`timescale 1ns/1ps
`include "oamd_cfg.svh"

////////////////////////////////////////////////////////////////////////
module testbench;
	logic                 clock_in = 1'b0;	// 200 MHz core clock
	logic                 sys_rst_in = 1'b1;	// Synchronous reset
	logic                 instr_valid_in;	// From stream model
	logic [23:0]          instr_in;	// From stream model
	logic [15:0]          pc_in = 16'h0000;	// Branch base
	logic [3:0]           reg_sel_in = 4'h0;	// Register to inspect
	logic                 instr_ready_out;
	oamd_pkg::oamd_ea_s   src_ea_out, dst_ea_out, x_ea_out, y_ea_out;
	oamd_pkg::oamd_dec_s  dec_out;
	logic [15:0]          reg_data_out;
	logic [15:0]          rm [16];	// Expected register contents
	int                   n_mismatch = 0;
	int                   tests_run = 0;
	int                   cyc = 0;

	always #2.5 clock_in = ~clock_in;

	oamd_stream_model u_oamd_stream_model (.clock_in(clock_in), .instr_ready_in(instr_ready_out),
		.instr_valid_out(instr_valid_in), .instr_out(instr_in));
	oamd_decode u_oamd_decode (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in),
		.instr_in(instr_in), .pc_in(pc_in), .reg_sel_in(reg_sel_in), .instr_ready_out(instr_ready_out),
		.src_ea_out(src_ea_out), .dst_ea_out(dst_ea_out), .x_ea_out(x_ea_out), .y_ea_out(y_ea_out),
		.dec_out(dec_out), .reg_data_out(reg_data_out));

	////////////////////////////////////////////////////////////////////////
	// Comparisons and reporting
	task automatic chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// A hang counts as a mismatch
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			test_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stimulus helpers
	task automatic go(input logic [23:0] w);
		logic ok;
		u_oamd_stream_model.send(w, ok);
		chk_bit("taken", 1'b1, ok);
		chk_bit("ready after take", 1'b0, instr_ready_out);
	endtask
	task automatic peek(input logic [3:0] r);
		reg_sel_in = r;
		repeat (2) @(posedge clock_in);
		#1;
		chk_word("register", rm[r], reg_data_out);
	endtask
	function automatic logic [23:0] mac(input logic [2:0] op, input logic xs, input logic [2:0] xm,
		input logic ys, input logic [2:0] ym, input logic [3:0] ofs);
		return {`OAMD_CLS_MAC, op, ofs, 5'h00, xs, xm, ys, ym};
	endfunction
	function automatic logic [23:0] mv(input logic [2:0] sm, input logic [2:0] dm, input logic [3:0] ofs,
		input logic [3:0] dr, input logic [1:0] lo, input logic [3:0] sr);
		return {`OAMD_CLS_MOVE, sm, dm, ofs, dr, lo, sr};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_other;
		go(24'h0fffff);
		chk_bit("nop src", 1'b0, src_ea_out.valid);
		chk_bit("nop x", 1'b0, x_ea_out.valid);
		chk_bit("nop operand", 1'b0, dec_out.has_operand);
		pc_in = 16'h1000;
		go(24'h30fffe);
		chk_word("branch target", 16'h0ffe, dec_out.branch_target);
		go(24'h4fc005);
		chk_word("disable count", 16'h0005, {2'b00, dec_out.interrupt_disable_count_op_count});
		go(24'h500000);
		chk_bit("unlink implied", 1'b1, dec_out.implied);
		go(24'h60ffa5);
		chk_word("literal 8", 16'h00a5, dec_out.lit);
		go(24'h70beef);
		chk_word("literal 16", 16'hbeef, dec_out.lit);
		go(24'h800000);
		chk_bit("unknown class flagged", 1'b1, dec_out.illegal);
		chk_bit("unknown class operand", 1'b0, dec_out.has_operand);
		$display("test other done");
	endtask

	task automatic t_mac;
		logic [2:0] xm, ym;
		for (int i = 0; i < 8; i++) begin
			xm = 3'(i % 4);
			ym = i[0] ? 3'h1 : 3'h0;
			go(mac(3'(i), 1'b0, xm, 1'b0, ym, 4'h0));
			chk_word("x address", rm[8], x_ea_out.addr);
			chk_word("y address", rm[10], y_ea_out.addr);
			chk_bit("x valid", 1'b1, x_ea_out.valid);
			rm[8]  = rm[8] + {12'h000, xm, 1'b0};
			rm[10] = rm[10] + {12'h000, ym, 1'b0};
		end
		peek(4'h8);
		peek(4'ha);
		go(mac(3'h3, 1'b1, 3'h4, 1'b1, 3'h4, 4'h8));
		chk_word("x indexed", rm[9] + rm[8], x_ea_out.addr);
		chk_word("y indexed", rm[11] + rm[8], y_ea_out.addr);
		go(mac(3'h4, 1'b0, 3'h4, 1'b0, 3'h4, 4'h8));
		chk_bit("x index refused", 1'b0, x_ea_out.valid);
		chk_bit("y index refused", 1'b0, y_ea_out.valid);
		go(mac(3'h1, 1'b0, 3'h7, 1'b1, 3'h7, 4'h0));
		chk_bit("x no prefetch", 1'b0, x_ea_out.valid);
		chk_bit("y no prefetch", 1'b0, y_ea_out.valid);
		$display("test mac done");
	endtask

	task automatic t_move;
		go(mv(oamd_pkg::OAMD_AM_IND, oamd_pkg::OAMD_AM_POSTI, 4'h0, 4'ha, 2'h0, 4'h8));
		chk_word("src ind", rm[8], src_ea_out.addr);
		chk_word("dst post", rm[10], dst_ea_out.addr);
		rm[10] = rm[10] + 16'h0002;
		go(mv(oamd_pkg::OAMD_AM_INDEX, oamd_pkg::OAMD_AM_LITOFS, 4'h8, 4'hb, 2'h3, 4'h9));
		chk_word("src indexed", rm[9] + rm[8], src_ea_out.addr);
		chk_word("dst lit ofs", rm[11] + 16'h0006, dst_ea_out.addr);
		go(mv(oamd_pkg::OAMD_AM_PREI, oamd_pkg::OAMD_AM_IND, 4'h0, 4'ha, 2'h0, 4'h9));
		rm[9] = rm[9] + 16'h0002;
		chk_word("src pre", rm[9], src_ea_out.addr);
		chk_word("dst ind", rm[10], dst_ea_out.addr);
		chk_bit("dst valid", 1'b1, dst_ea_out.valid);
		go(mv(oamd_pkg::OAMD_AM_DIRECT, oamd_pkg::OAMD_AM_LIT8, 4'h0, 4'h3, 2'h0, 4'h2));
		chk_bit("src direct", 1'b0, src_ea_out.valid);
		chk_bit("dst lit8", 1'b0, dst_ea_out.valid);
		go(mv(oamd_pkg::OAMD_AM_LIT16, oamd_pkg::OAMD_AM_DIRECT, 4'h0, 4'h3, 2'h0, 4'h2));
		chk_bit("src lit16", 1'b0, src_ea_out.valid);
		chk_bit("dst direct", 1'b0, dst_ea_out.valid);
		peek(4'h9);
		peek(4'ha);
		$display("test move done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		foreach (rm[i])
			rm[i] = 16'h0000;
		repeat (16) @(posedge clock_in);
		#1;
		sys_rst_in = 1'b0;
		chk_bit("ready after reset", 1'b1, instr_ready_out);
		t_other();
		t_mac();
		t_move();
		test_done;
	end
endmodule // testbench
